//--- core/exec_state_timer.sv
// Notes on behaviour
// [RULE1] Total states = sum of count times cost
// [RULE2] Six fixed cycle counts per instruction
// [RULE3] Fetch and RAM byte access: 2 states
// [RULE4] Branch read and stack: 2 states
// [RULE5] Peripheral byte access: 2 or 3 states
// [RULE6] Add fetches: 1, 2 or 3
// [RULE7] AND fetches: 1, 2, 3; long register 2
// [RULE8] Bit-AND carry: memory forms two fetches and one byte access
// [RULE9] Short branches: exactly two fetches only
// [RULE10] Counter holds instruction until total elapses
// [RULE11] Internal one state; small ops one fetch
module exec_state_timer (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic issue_valid_i,
    input wire cpu_timing_pkg::issue_s issue_i,
    output logic issue_ready_o,
    output logic busy_o,
    output logic done_o,
    output cpu_timing_pkg::cycle_counts_s counts_o,
    output logic [cpu_timing_pkg::TOTAL_W-1:0] total_o,
    output logic [cpu_timing_pkg::TOTAL_W-1:0] elapsed_o
);
    import cpu_timing_pkg::*;

    typedef enum logic {idle, running} phase_e;

    phase_e phase;
    cycle_counts_s next_counts;
    logic [TOTAL_W-1:0] next_total;
    logic accept;
    logic last_state;

    // ****************************************
    // Cycle-count decode
    // ****************************************
    always_comb begin
        next_counts = '0; // [RULE2]
        next_counts.fetch = CNT_ONE;
        unique case (issue_i.kind)
            add_b_imm, add_b_reg, add_w_reg, add_l_reg: begin
                next_counts.fetch = CNT_ONE; // [RULE6]
            end
            add_w_imm: begin
                next_counts.fetch = CNT_TWO; // [RULE6]
            end
            add_l_imm: begin
                next_counts.fetch = CNT_THREE; // [RULE6]
            end
            address_add_small_const, add_with_carry_in_imm, add_with_carry_in_reg, and_to_condition_code: begin
                next_counts.fetch = CNT_ONE; // [RULE11]
            end
            and_b_imm, and_b_reg, and_w_reg: begin
                next_counts.fetch = CNT_ONE; // [RULE7]
            end
            and_w_imm, and_l_reg: begin
                next_counts.fetch = CNT_TWO; // [RULE7]
            end
            and_l_imm: begin
                next_counts.fetch = CNT_THREE; // [RULE7]
            end
            bit_and_carry_reg: begin
                next_counts.fetch = CNT_ONE; // [RULE8]
            end
            bit_and_carry_indirect, bit_and_carry_abs8: begin
                next_counts.fetch = CNT_TWO; // [RULE8]
                next_counts.byte_data = CNT_ONE;
            end
            branch_disp8: begin
                // Same cost taken or not: no condition input needed
                next_counts.fetch = CNT_TWO; // [RULE9]
            end
            default: begin
                // Unknown class: charge one fetch rather than stall the core
                next_counts.fetch = CNT_ONE;
            end
        endcase
    end

    state_cost_calc cost_calc (
        .counts_i(next_counts),
        .loc_i(issue_i.loc),
        .total_o(next_total)
    );

    // ****************************************
    // Issue handshake and state counting
    // ****************************************
    assign issue_ready_o = (phase == idle);
    assign accept = issue_valid_i && issue_ready_o;
    assign last_state = (elapsed_o == total_o);
    assign busy_o = (phase == running);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= idle;
        end else if (accept) begin
            phase <= running;
        end else if (phase == running && last_state) begin
            phase <= idle; // [RULE10]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            elapsed_o <= '0;
        end else if (accept) begin
            elapsed_o <= TOTAL_W'(1);
        end else if (phase == running && !last_state) begin
            elapsed_o <= elapsed_o + TOTAL_W'(1); // [RULE10]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            total_o <= '0;
            counts_o <= '0;
        end else if (accept) begin
            total_o <= next_total; // [RULE1]
            counts_o <= next_counts;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (phase == running) && last_state; // [RULE10]
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [TOTAL_W-1:0] gap;
    logic [TOTAL_W-1:0] prev_total;
    logic seen_one;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap <= '0;
            prev_total <= '0;
            seen_one <= 1'b0;
        end else if (accept) begin
            gap <= TOTAL_W'(1);
            prev_total <= next_total;
            seen_one <= 1'b1;
        end else if (gap != '1) begin
            gap <= gap + TOTAL_W'(1);
        end
    end

    // Done cycle sits between runs, so back to back issue is total + 1 edges apart
    a_issue_spacing: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE10]
        accept && seen_one |-> gap > prev_total)
        else $error("instruction issued before its states elapsed");
    a_idle_next_cycle: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE10]
        busy_o && last_state |=> issue_ready_o && done_o)
        else $error("timer did not release after last state");
    a_memory_sum: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE1]
        accept && !issue_i.loc.data_periph |=> total_o == 2 * (counts_o.fetch + counts_o.byte_data
            + counts_o.word_data + counts_o.branch_read + counts_o.stack) + counts_o.internal)
        else $error("on-chip memory total mismatch");
    a_no_other_cycles: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE2]
        busy_o |-> counts_o.branch_read == 0 && counts_o.stack == 0 && counts_o.word_data == 0)
        else $error("unexpected cycle type counted");
    a_byte_add_two: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE3]
        accept && issue_i.kind == add_b_imm |=> total_o == 2 ##2 done_o)
        else $error("byte add not two states");
    a_periph_slow: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE5]
        accept && issue_i.kind == bit_and_carry_indirect && issue_i.loc.data_periph
        |=> total_o == ($past(issue_i.loc.periph_slow) ? 7 : 6))
        else $error("peripheral byte access cost wrong");
    a_add_long_imm: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE6]
        accept && issue_i.kind == add_l_imm |=> counts_o.fetch == 3 && total_o == 6)
        else $error("long immediate add wrong");
    a_and_long_reg: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE7]
        accept && issue_i.kind == and_l_reg |=> total_o == 4 [*4] ##1 done_o)
        else $error("long register AND wrong");
    a_bit_and_mem: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE8]
        accept && issue_i.kind == bit_and_carry_abs8 && !issue_i.loc.data_periph
        |=> counts_o.byte_data == 1 && total_o == 6)
        else $error("bit AND memory form wrong");
    a_branch_short: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE9]
        accept && issue_i.kind == branch_disp8 |=> busy_o [*4] ##1 done_o)
        else $error("short branch not four states");
    a_cond_code_and: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE11]
        accept && issue_i.kind == and_to_condition_code |=> total_o == 2 && counts_o.internal == 0)
        else $error("condition code AND wrong");
    a_slow_abs8: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE5]
        accept && issue_i.kind == bit_and_carry_abs8 && issue_i.loc.data_periph && issue_i.loc.periph_slow
        |=> total_o == 7)
        else $error("slow peripheral bit AND not seven states");
    a_branch_fetch_only: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE9]
        accept && issue_i.kind == branch_disp8 |=> counts_o.fetch == 2 && counts_o.byte_data == 0
            && counts_o.internal == 0)
        else $error("short branch counted other cycles");
    a_start_count: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE10]
        accept |=> busy_o && elapsed_o == 1)
        else $error("state count did not start at one");
    a_elapsed_bound: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE10]
        busy_o |-> elapsed_o >= 1 && elapsed_o <= total_o)
        else $error("state count out of range");
    a_totals_held: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE10]
        busy_o |=> $stable(total_o) && $stable(counts_o))
        else $error("totals changed while running");
    a_done_single: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE10]
        done_o |=> !done_o)
        else $error("done longer than one cycle");

    // ****************************************
    // Scenario covers
    // ****************************************
    c_branch: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        accept && issue_i.kind == branch_disp8);
    c_slow_periph: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        accept && issue_i.loc.data_periph && issue_i.loc.periph_slow && issue_i.kind == bit_and_carry_indirect);
    c_back_to_back: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        done_o && accept);
    c_refused_offer: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        issue_valid_i && busy_o);
    c_fast_periph: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        accept && issue_i.loc.data_periph && !issue_i.loc.periph_slow && issue_i.kind == bit_and_carry_abs8);

endmodule

//--- core/cpu_timing_pkg.sv
package cpu_timing_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int CNT_W = 4;
    localparam int COST_W = 2;
    localparam int TOTAL_W = 9;

    // ****************************************
    // State cost of one cycle, by access location
    // ****************************************
    localparam logic [COST_W-1:0] COST_FETCH_MEM = 2'h2;
    localparam logic [COST_W-1:0] COST_BRANCH_MEM = 2'h2;
    localparam logic [COST_W-1:0] COST_STACK_MEM = 2'h2;
    localparam logic [COST_W-1:0] COST_DATA_MEM = 2'h2;
    localparam logic [COST_W-1:0] COST_PERIPH_FAST = 2'h2;
    localparam logic [COST_W-1:0] COST_PERIPH_SLOW = 2'h3;
    localparam logic [COST_W-1:0] COST_INTERNAL = 2'h1;

    // ****************************************
    // Cycle counts used by the decode table
    // ****************************************
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_TWO = 4'h2;
    localparam logic [CNT_W-1:0] CNT_THREE = 4'h3;

    typedef enum logic [4:0] {
        add_b_imm,
        add_b_reg,
        add_w_imm,
        add_w_reg,
        add_l_imm,
        add_l_reg,
        address_add_small_const,
        add_with_carry_in_imm,
        add_with_carry_in_reg,
        and_b_imm,
        and_b_reg,
        and_w_imm,
        and_w_reg,
        and_l_imm,
        and_l_reg,
        and_to_condition_code,
        bit_and_carry_reg,
        bit_and_carry_indirect,
        bit_and_carry_abs8,
        branch_disp8
    } instr_e;

    typedef struct packed {
        logic [CNT_W-1:0] fetch;
        logic [CNT_W-1:0] branch_read;
        logic [CNT_W-1:0] stack;
        logic [CNT_W-1:0] byte_data;
        logic [CNT_W-1:0] word_data;
        logic [CNT_W-1:0] internal;
    } cycle_counts_s;

    typedef struct packed {
        logic data_periph;
        logic periph_slow;
    } access_loc_s;

    typedef struct packed {
        instr_e kind;
        access_loc_s loc;
    } issue_s;

endpackage

//--- core/state_cost_calc.sv
module state_cost_calc (
    input wire cpu_timing_pkg::cycle_counts_s counts_i,
    input wire cpu_timing_pkg::access_loc_s loc_i,
    output logic [cpu_timing_pkg::TOTAL_W-1:0] total_o
);
    import cpu_timing_pkg::*;

    logic [COST_W-1:0] data_cost;

    // Peripheral data cost depends on which module is addressed
    assign data_cost = !loc_i.data_periph ? COST_DATA_MEM :
                       (loc_i.periph_slow ? COST_PERIPH_SLOW : COST_PERIPH_FAST); // [RULE5]

    // Weighted sum over the six cycle types
    assign total_o = TOTAL_W'(counts_i.fetch) * TOTAL_W'(COST_FETCH_MEM)
                   + TOTAL_W'(counts_i.branch_read) * TOTAL_W'(COST_BRANCH_MEM)
                   + TOTAL_W'(counts_i.stack) * TOTAL_W'(COST_STACK_MEM)
                   + TOTAL_W'(counts_i.byte_data) * TOTAL_W'(data_cost)
                   + TOTAL_W'(counts_i.word_data) * TOTAL_W'(data_cost)
                   + TOTAL_W'(counts_i.internal) * TOTAL_W'(COST_INTERNAL); // [RULE1] [RULE3] [RULE4]

endmodule

//--- dv/onchip_access_model.sv
module onchip_access_model (
    input wire logic [1:0] target_i,
    output cpu_timing_pkg::access_loc_s loc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_timing_pkg::*;

    // ****************************************
    // Target 0 is RAM, 1 a two-state, 2 a three-state peripheral
    // ****************************************
    assign loc_o.data_periph = (target_i != 2'h0);
    assign loc_o.periph_slow = (target_i == 2'h2);
endmodule

//--- dv/cpu_execution_state_timing_bench.sv
module cpu_execution_state_timing_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_timing_pkg::*;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic issue_valid = 1'b0;
    instr_e kind = add_b_imm;
    logic [1:0] target = 2'h0;
    access_loc_s loc;
    logic ready;
    logic busy;
    logic done;
    cycle_counts_s counts;
    logic [TOTAL_W-1:0] total;
    logic [TOTAL_W-1:0] elapsed;
    int err_total = 0;
    int num_checks = 0;

    initial forever #10 clock = ~clock;

    onchip_access_model u_mem (.target_i(target), .loc_o(loc));

    exec_state_timer u_dut (
        .clock_i(clock), .rst_n_i(rst_n), .issue_valid_i(issue_valid), .issue_i({kind, loc}),
        .issue_ready_o(ready), .busy_o(busy), .done_o(done), .counts_o(counts),
        .total_o(total), .elapsed_o(elapsed)
    );

    // ****************************************
    // Shared checking
    // ****************************************
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    function automatic int exp_fetch(input instr_e k);
        case (k)
            add_w_imm, and_w_imm, and_l_reg, bit_and_carry_indirect, bit_and_carry_abs8, branch_disp8: return 2;
            add_l_imm, and_l_imm: return 3;
            default: return 1;
        endcase
    endfunction

    function automatic int exp_byte(input instr_e k);
        return (k == bit_and_carry_indirect || k == bit_and_carry_abs8) ? 1 : 0;
    endfunction

    // Bounded wait from the cycle after accept; n is that cycle's index
    task automatic wait_done(output int n);
        n = 1;
        while (done !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        if (n >= 40) begin
            err_total++;
            test_done();
        end
    endtask

    // Called right after a done cycle, so runs are back to back
    task automatic run_one(input instr_e k, input logic [1:0] tgt);
        int n;
        int tot;
        tot = exp_fetch(k) * 2 + exp_byte(k) * ((tgt == 2'h2) ? 3 : 2);
        kind = k;
        target = tgt;
        issue_valid = 1'b1;
        check(9'(ready), 9'h001);
        @(posedge clock);
        @(negedge clock);
        issue_valid = 1'b0;
        check(9'(busy), 9'h001);
        check(9'(counts.fetch), 9'(exp_fetch(k)));
        check(9'(counts.byte_data), 9'(exp_byte(k)));
        check(9'(counts.branch_read | counts.stack | counts.word_data | counts.internal), 9'h000);
        check(total, 9'(tot));
        wait_done(n);
        check(9'(n), 9'(tot + 1));
        check(elapsed, 9'(tot));
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic scen_add;
        for (int i = 0; i < 6; i++) run_one(instr_e'(i), 2'h0);
    endtask

    task automatic scen_and;
        for (int i = 9; i < 15; i++) run_one(instr_e'(i), 2'h0);
    endtask

    task automatic scen_misc;
        run_one(address_add_small_const, 2'h1);
        run_one(add_with_carry_in_imm, 2'h2);
        run_one(add_with_carry_in_reg, 2'h0);
        run_one(and_to_condition_code, 2'h0);
    endtask

    // Memory forms against RAM, fast and slow peripheral
    task automatic scen_bit;
        run_one(bit_and_carry_reg, 2'h2);
        for (int t = 0; t < 3; t++) begin
            run_one(bit_and_carry_indirect, 2'(t));
            run_one(bit_and_carry_abs8, 2'(t));
        end
    endtask

    // Second offer while busy is refused, held, and taken in the done cycle
    task automatic scen_refuse;
        int n;
        run_one(branch_disp8, 2'h0);
        kind = branch_disp8;
        issue_valid = 1'b1;
        @(posedge clock);
        @(negedge clock);
        kind = add_l_imm;
        check(9'(ready), 9'h000);
        repeat (2) @(negedge clock);
        check(9'(counts.fetch), 9'h002);
        wait_done(n);
        check(9'(n + 2), 9'h005);
        check(total, 9'h004);
        check(9'(ready), 9'h001);
        @(posedge clock);
        @(negedge clock);
        issue_valid = 1'b0;
        check(9'(counts.fetch), 9'h003);
        check(total, 9'h006);
        wait_done(n);
        check(9'(n), 9'h007);
    endtask

    initial begin
        repeat (16) @(negedge clock);
        check(9'({ready, busy, done}), 9'h004);
        check(total, 9'h000);
        rst_n = 1'b1;
        scen_add();
        scen_and();
        scen_misc();
        scen_bit();
        scen_refuse();
        test_done();
    end
endmodule
